// ==== verilog/usr_pkg.sv ====
package usr_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int          STAGES     = 8;
  localparam int          CLK_MHZ    = 10;
  localparam real         REC_NS     = 7.0;
  // Clear recovery in clk cycles, rounded up, at least one
  localparam int          REC_CYC    = (int'(REC_NS * CLK_MHZ) + 999) / 1000 < 1 ? 1 :
                                       (int'(REC_NS * CLK_MHZ) + 999) / 1000;
  localparam int          FIFO_DEPTH = 2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_COUNT  = 4'h8;
  localparam int          CTRL_INHIBIT_BIT = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam int          STAT_STAGE_LSB = 0;
  localparam int          STAT_MODE_LSB  = 8;
  localparam int          STAT_DRIVE_BIT = 10;
  localparam int          STAT_FILL_LSB  = 12;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    USR_HOLD,
    USR_SHIFT_RIGHT,
    USR_SHIFT_LEFT,
    USR_LOAD
  } usr_mode_t;

  // Word handed to the capture stream after each clock edge that finds room in the buffer
  typedef struct packed {
    usr_mode_t        mode;
    logic [STAGES-1:0] stages;
  } usr_tap_t;

  // Select pins to operation
  function automatic usr_mode_t usr_decode(input logic sel_hi, input logic sel_lo);
    usr_mode_t m;
    m = USR_HOLD;
    unique case ({sel_hi, sel_lo})
      2'b00: m = USR_HOLD;
      2'b01: m = USR_SHIFT_RIGHT;
      2'b10: m = USR_SHIFT_LEFT;
      2'b11: m = USR_LOAD;
    endcase
    return m;
  endfunction

endpackage

// ==== verilog/usr_shift_reg.sv ====
// Notes on behaviour
// R1: eight flip-flop stages, shift, load, hold
// R2: two select inputs alone choose operation
// R3: changes only on shift_clock rising edge
// R4: clear low zeroes all stages immediately
// R5: both selects high loads bus
// R6: low-high selects shift toward stage 7
// R7: high-low selects shift toward stage 0
// R8: both selects low holds contents
// R9: stages drive bus, bus supplies load data
// R10: first and last stages always driven
// R11: either enable high releases bus
// R12: operations continue while bus released
// R13: load mode releases bus regardless
// R14: other side supplies right serial bit
// R15: other side supplies left serial bit
// R16: other side drives bus only in load
// R17: drive only with enables low, not load
// R18: other side honours clear recovery time
module usr_shift_reg
  import usr_pkg::*;
#(
  parameter int DEPTH = usr_pkg::FIFO_DEPTH
) (
  input  wire logic                      clk,              // 10 MHz system clock
  input  wire logic                      arst_n,           // Async reset, active low
  input  wire logic                      shift_clock,      // Shift clock pin, sampled
  input  wire logic                      master_clear_n,   // Async clear, active low
  input  wire logic                      mode_sel_lo,      // Mode select low bit
  input  wire logic                      mode_sel_hi,      // Mode select high bit
  input  wire logic                      right_serial_in,  // Serial in, right shift
  input  wire logic                      left_serial_in,   // Serial in, left shift
  input  wire logic                      bus_enable_a_n,   // Bus enable A, active low
  input  wire logic                      bus_enable_b_n,   // Bus enable B, active low
  input  wire logic [usr_pkg::STAGES-1:0] parallel_bus_in, // Bus level seen at pins
  output logic      [usr_pkg::STAGES-1:0] parallel_bus_out, // Bus drive value
  output logic      [usr_pkg::STAGES-1:0] parallel_bus_oe,  // Bus drive enable, per line
  output logic                           first_stage_tap,  // Stage 0
  output logic                           last_stage_tap,   // Stage 7
  output logic                           tap_valid,        // Capture word available
  input  wire logic                      tap_ready,        // Capture sink ready
  output usr_pkg::usr_tap_t              tap_data,         // Capture word
  output logic                           tap_in_ready,     // Capture buffer has room
  input  wire logic [3:0]                s_axi_awaddr,     // AXI write address
  input  wire logic                      s_axi_awvalid,    // AXI write address valid
  output logic                           s_axi_awready,    // AXI write address ready
  input  wire logic [31:0]               s_axi_wdata,      // AXI write data
  input  wire logic [3:0]                s_axi_wstrb,      // AXI write strobes
  input  wire logic                      s_axi_wvalid,     // AXI write data valid
  output logic                           s_axi_wready,     // AXI write data ready
  output logic [1:0]                     s_axi_bresp,      // AXI write response
  output logic                           s_axi_bvalid,     // AXI write response valid
  input  wire logic                      s_axi_bready,     // AXI write response ready
  input  wire logic [3:0]                s_axi_araddr,     // AXI read address
  input  wire logic                      s_axi_arvalid,    // AXI read address valid
  output logic                           s_axi_arready,    // AXI read address ready
  output logic [31:0]                    s_axi_rdata,      // AXI read data
  output logic [1:0]                     s_axi_rresp,      // AXI read response
  output logic                           s_axi_rvalid,     // AXI read data valid
  input  wire logic                      s_axi_rready      // AXI read data ready
);
  import usr_pkg::*;

  localparam int FILL_W = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // Mode decode and clock edge
  // ----------------------------------------------------------------
  logic              clr_n;
  logic              clk_prev;
  logic              clk_rise;
  usr_mode_t         mode;
  logic [STAGES-1:0] stage;
  logic [STAGES-1:0] next_stage;
  logic              inhibit;

  // Clear acts without the clock
  assign clr_n    = arst_n & master_clear_n;            // [R4]
  assign mode     = usr_decode(mode_sel_hi, mode_sel_lo); // [R2]
  assign clk_rise = shift_clock & ~clk_prev;             // [R3]

  // Previous shift clock level
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= shift_clock;
    end
  end

  // ----------------------------------------------------------------
  // Stage next values
  // ----------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < STAGES; n++) begin : g_stage
      logic from_lower;
      logic from_upper;
      assign from_lower = (n == 0) ? right_serial_in : stage[(n == 0) ? 0 : n - 1]; // [R14]
      assign from_upper = (n == STAGES - 1) ? left_serial_in :
                          stage[(n == STAGES - 1) ? n : n + 1];                   // [R15]
      // Per-stage mux
      always_comb begin
        unique case (mode)
          USR_HOLD:        next_stage[n] = stage[n];           // [R8]
          USR_SHIFT_RIGHT: next_stage[n] = from_lower;         // [R6]
          USR_SHIFT_LEFT:  next_stage[n] = from_upper;         // [R7]
          USR_LOAD:        next_stage[n] = parallel_bus_in[n]; // [R5] [R9]
        endcase
      end
    end
  endgenerate

  // Stage flip-flops; independent of bus drive state
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      stage <= '0;                    // [R4]
    end else if (clk_rise) begin
      stage <= next_stage;            // [R1] [R3] [R12]
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  logic drive;

  // Drive only when both enables low, not loading, not inhibited
  assign drive = ~bus_enable_a_n & ~bus_enable_b_n & (mode != USR_LOAD) & ~inhibit; // [R11] [R13] [R17]
  assign parallel_bus_oe  = {STAGES{drive}};  // [R9]
  assign parallel_bus_out = stage;            // [R9]
  assign first_stage_tap  = stage[0];         // [R10]
  assign last_stage_tap   = stage[STAGES-1];  // [R10]

  // ----------------------------------------------------------------
  // Capture buffer
  // ----------------------------------------------------------------
  usr_tap_t          buf_mem [DEPTH];
  logic [FILL_W-1:0] fill;
  logic              wr_ptr;
  logic              rd_ptr;
  logic              pushed;
  logic              push;
  logic              pop;

  // Word posted the cycle after each edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pushed <= 1'b0;
    end else begin
      pushed <= clk_rise & master_clear_n;
    end
  end

  assign tap_in_ready = (fill != FILL_W'(DEPTH));
  assign tap_valid    = (fill != '0);
  assign push         = pushed & tap_in_ready;
  assign pop          = tap_valid & tap_ready;
  assign tap_data     = buf_mem[rd_ptr];

  // Buffer storage
  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr] <= '{mode: mode, stages: stage};
    end
  end

  // Buffer pointers and fill level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fill <= fill + FILL_W'(push) - FILL_W'(pop);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] words_seen;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] next_rdata;
  logic        rd_hit;

  assign inhibit       = ctrl[CTRL_INHIBIT_BIT];
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;

  // Control register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RESET;
    end else if (wr_go && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0]) begin
      ctrl <= {31'h0, s_axi_wdata[CTRL_INHIBIT_BIT]};
    end
  end

  // Write response
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Counter of words accepted into the capture buffer, for software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      words_seen <= 16'h0000;
    end else if (push) begin
      words_seen <= words_seen + 16'h0001;
    end
  end

  // Read decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL: next_rdata = ctrl;
      ADDR_STATUS: begin
        next_rdata[STAT_STAGE_LSB +: STAGES] = stage;
        next_rdata[STAT_MODE_LSB +: 2]       = mode;
        next_rdata[STAT_DRIVE_BIT]           = drive;
        next_rdata[STAT_FILL_LSB +: FILL_W]  = fill;
      end
      ADDR_COUNT: next_rdata[15:0] = words_seen;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_clear_zeroes: assert property (@(posedge clk) // [R4]
    !master_clear_n |-> stage == '0)                                    // [R4]
    else $error("stages not zero during clear");

  a_edge_only: assert property (@(posedge clk) disable iff (!clr_n) // [R3]
    !$past(clk_rise) |-> stage == $past(stage))                          // [R3]
    else $error("stages changed without a clock edge");

  a_load_bus: assert property (@(posedge clk) disable iff (!clr_n) // [R5]
    clk_rise && mode_sel_hi && mode_sel_lo |=> stage == $past(parallel_bus_in)) // [R5]
    else $error("parallel load wrong");

  a_shift_right: assert property (@(posedge clk) disable iff (!clr_n) // [R6]
    clk_rise && !mode_sel_hi && mode_sel_lo |=>
      stage == {$past(stage[STAGES-2:0]), $past(right_serial_in)})      // [R6]
    else $error("right shift wrong");

  a_shift_left: assert property (@(posedge clk) disable iff (!clr_n) // [R7]
    clk_rise && mode_sel_hi && !mode_sel_lo |=>
      stage == {$past(left_serial_in), $past(stage[STAGES-1:1])})       // [R7]
    else $error("left shift wrong");

  a_hold_keeps: assert property (@(posedge clk) disable iff (!clr_n) // [R8]
    !mode_sel_hi && !mode_sel_lo |=> $stable(stage))                     // [R8]
    else $error("hold changed stages");

  a_release_bus: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
    (bus_enable_a_n || bus_enable_b_n || (mode_sel_hi && mode_sel_lo))
      |-> parallel_bus_oe == '0)                                         // [R11]
    else $error("bus driven while released");

  a_drive_bus: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
    !bus_enable_a_n && !bus_enable_b_n && !(mode_sel_hi && mode_sel_lo) && !inhibit
      |-> parallel_bus_oe == '1 && parallel_bus_out == stage)            // [R17]
    else $error("bus not driven with stages");

  a_taps_follow: assert property (@(posedge clk) // [R10]
    first_stage_tap == stage[0] && last_stage_tap == stage[STAGES-1])    // [R10]
    else $error("serial taps wrong");

  a_shift_offbus: assert property (@(posedge clk) disable iff (!clr_n) // [R12]
    clk_rise && bus_enable_a_n && mode_sel_lo && !mode_sel_hi ##1 1'b1
      |-> stage[1] == $past(stage[0]))                                   // [R12]
    else $error("shift lost while bus released");

  a_clear_pins: assert property (@(posedge clk) // [R4]
    !master_clear_n |-> parallel_bus_out == '0 && !first_stage_tap && !last_stage_tap)
    else $error("pins not low during clear");

  a_single_step: assert property (@(posedge clk) disable iff (!clr_n) // [R3]
    clk_rise |=> !clk_rise)
    else $error("one pin edge counted twice");

  a_right_taps: assert property (@(posedge clk) disable iff (!clr_n) // [R6]
    clk_rise && !mode_sel_hi && mode_sel_lo |=>
      first_stage_tap == $past(right_serial_in) && last_stage_tap == $past(stage[STAGES-2]))
    else $error("taps wrong after right shift");

  a_left_taps: assert property (@(posedge clk) disable iff (!clr_n) // [R7]
    clk_rise && mode_sel_hi && !mode_sel_lo |=>
      last_stage_tap == $past(left_serial_in) && first_stage_tap == $past(stage[1]))
    else $error("taps wrong after left shift");

  a_hold_offbus: assert property (@(posedge clk) disable iff (!clr_n) // [R12]
    clk_rise && bus_enable_b_n && !mode_sel_hi && !mode_sel_lo |=> $stable(stage))
    else $error("hold lost while bus released");

  a_load_undriven: assert property (@(posedge clk) disable iff (!arst_n) // [R13]
    mode_sel_hi && mode_sel_lo && !bus_enable_a_n && !bus_enable_b_n
      |-> parallel_bus_oe == '0)
    else $error("bus driven during load");

  a_bus_shows: assert property (@(posedge clk) disable iff (!clr_n) // [R9]
    clk_rise && mode_sel_lo && !mode_sel_hi |=>
      !drive || parallel_bus_out == {$past(stage[STAGES-2:0]), $past(right_serial_in)})
    else $error("bus does not show shifted stages");

endmodule

// ==== dv/usr_far_end.sv ====
module usr_far_end
  import usr_pkg::*;
(
  input  wire logic [usr_pkg::STAGES-1:0] load_data, // Word offered in load mode
  input  wire logic [usr_pkg::STAGES-1:0] dev_out,   // Device drive value
  input  wire logic [usr_pkg::STAGES-1:0] dev_oe,    // Device drive enable
  input  wire logic                       clk,       // System clock
  input  wire logic                       sel_lo,    // Mode select low bit
  input  wire logic                       sel_hi,    // Mode select high bit
  output logic      [usr_pkg::STAGES-1:0] bus        // Resolved bus level
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [STAGES-1:0] last_bus = '0;

  // Remember the level so a floating line can show its inverse
  always_ff @(posedge clk) begin
    last_bus <= bus;
  end

  // Offer load data only while load mode releases the bus
  always_comb begin
    for (int i = 0; i < STAGES; i++) begin
      bus[i] = dev_oe[i] ? dev_out[i] : (sel_hi && sel_lo) ? load_data[i] : ~last_bus[i];
    end
  end
endmodule

// ==== dv/usr_shift_reg_bench.sv ====
module usr_shift_reg_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import usr_pkg::*;

  logic              clk, arst_n, shift_clock, master_clear_n, mode_sel_lo, mode_sel_hi;
  logic              right_serial_in, left_serial_in, bus_enable_a_n, bus_enable_b_n;
  logic              tap_valid, tap_ready, tap_in_ready, first_stage_tap, last_stage_tap;
  logic [STAGES-1:0] bus, bus_out, bus_oe, load_data, st;
  usr_tap_t          tap_data;
  logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, stall, inhib;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [1:0]        s_axi_bresp, s_axi_rresp, cur_mode;
  int                mismatches, compares, pushed, seed;
  usr_tap_t          notes[$];

  // Free-running system clock
  always #50 clk = ~clk;

  usr_shift_reg u_usr_shift_reg (.*, .parallel_bus_in(bus), .parallel_bus_out(bus_out),
                                 .parallel_bus_oe(bus_oe));

  usr_far_end u_usr_far_end (.clk(clk), .sel_lo(mode_sel_lo), .sel_hi(mode_sel_hi),
                             .load_data(load_data), .dev_out(bus_out), .dev_oe(bus_oe),
                             .bus(bus));

  // --------------------------------
  // Checking and closing
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bail;
    mismatches++;
    $display("BAD %0t: wait ran out", $time);
    report_and_stop();
  endtask

  // Capture words leave in order; compare each against the oldest note
  always @(posedge clk) begin
    if (arst_n && tap_valid === 1'b1 && tap_ready === 1'b1) begin
      if (notes.size() == 0)
        check(32'h1, 32'h0);
      else
        check(tap_data, notes.pop_front());
    end
  end

  // --------------------------------
  // Bus and pin drivers
  // --------------------------------
  task automatic await_resp(input logic rd);
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if ((rd ? s_axi_rvalid : s_axi_bvalid) === 1'b1) break;
    end
    if (k == 50) bail();
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    int   k;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {aw, w} = 2'h3;
    for (k = 0; k < 50 && (aw || w); k++) begin
      @(posedge clk);
      if (aw && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      aw = aw && s_axi_awready !== 1'b1;
      w = w && s_axi_wready !== 1'b1;
    end
    if (aw || w) bail();
    await_resp(1'b0);
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] mask, exp, input logic [1:0] er);
    int k;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) break;
    end
    if (k == 50) bail();
    s_axi_arvalid <= 1'b0;
    await_resp(1'b1);
    check(s_axi_rdata & mask, exp);
    check(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  // One shift clock pulse in mode m, then compare the pins
  task automatic op(input logic [1:0] m, input logic [7:0] d, input logic keep);
    logic rs, ls;
    @(posedge clk);
    rs = 1'($random(seed));
    ls = 1'($random(seed));
    cur_mode = m;
    shift_clock <= 1'b0;
    {mode_sel_hi, mode_sel_lo} <= m;
    {right_serial_in, left_serial_in} <= {rs, ls};
    load_data <= d;
    {bus_enable_a_n, bus_enable_b_n} <= 2'($random(seed));
    tap_ready <= stall ? 1'b0 : 1'($random(seed));
    @(posedge clk);
    shift_clock <= 1'b1;
    #1 check(bus_out, st);
    @(posedge clk);
    tap_ready <= !stall;
    if (!master_clear_n) st = '0;
    else if (m == 2'b01) st = {st[6:0], rs};
    else if (m == 2'b10) st = {ls, st[7:1]};
    else if (m == 2'b11) st = d;
    if (master_clear_n && keep) notes.push_back(usr_tap_t'({m, st}));
    if (master_clear_n) pushed++;
    @(posedge clk);
    check({first_stage_tap, last_stage_tap}, {st[0], st[7]});
    check(bus_out, st);
    check(bus_oe, {8{!bus_enable_a_n && !bus_enable_b_n && m != 2'b11 && !inhib}});
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {clk, arst_n, shift_clock, mode_sel_lo, mode_sel_hi, stall, inhib} = '0;
    {right_serial_in, left_serial_in, bus_enable_a_n, bus_enable_b_n} = '0;
    {master_clear_n, tap_ready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 14'h2000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_wdata, load_data, st, cur_mode} = '0;
    {mismatches, compares, pushed} = '0;
    seed = 32'hEA7A;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check({first_stage_tap, last_stage_tap, tap_valid, bus_out}, 32'h0);
    for (int m = 0; m < 4; m++) op(2'(m), 8'h5A, 1'b1);
    for (int i = 0; i < 48; i++) op(2'($random(seed)), 8'($random(seed)), 1'b1);
    $display("test modes done");
    axr(ADDR_STATUS, 32'h3FF, {cur_mode, st}, RESP_OKAY);
    axr(ADDR_COUNT, 32'hFFFF, pushed, RESP_OKAY);
    axr(4'hC, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    axw(ADDR_STATUS, 32'h0, RESP_SLVERR);
    axw(ADDR_CTRL, 32'h1, RESP_OKAY);
    inhib = 1'b1;
    axr(ADDR_CTRL, 32'h1, 32'h1, RESP_OKAY);
    repeat (4) op(2'b00, 8'h00, 1'b1);
    axw(ADDR_CTRL, 32'h0, RESP_OKAY);
    inhib = 1'b0;
    $display("test registers done");
    op(2'b11, 8'hA5, 1'b1);
    @(posedge clk);
    master_clear_n <= 1'b0;
    #10;
    check({first_stage_tap, last_stage_tap, bus_out}, 32'h0);
    st = '0;
    op(2'b11, 8'h3C, 1'b1);
    @(posedge clk);
    master_clear_n <= 1'b1;
    op(2'b01, 8'h00, 1'b1);
    $display("test clear done");
    stall = 1'b1;
    op(2'b00, 8'h00, 1'b1);
    op(2'b10, 8'h00, 1'b1);
    @(posedge clk);
    check(tap_in_ready, 1'b0);
    op(2'b01, 8'h00, 1'b0);
    stall = 1'b0;
    // Drain the full buffer so the next word is not refused
    tap_ready <= 1'b1;
    repeat (2) @(posedge clk);
    op(2'b00, 8'h00, 1'b1);
    for (int k = 0; k < 20 && notes.size() != 0; k++) @(posedge clk);
    check(notes.size(), 32'h0);
    $display("test stall done");
    report_and_stop();
  end
endmodule
